//--- pps_core.sv
// Purpose: instruction sequencing core with phase generator, pc and stack
// Assumes: instruction class and target arrive decoded with the fetch word
// Notes: registers reached over apb; one instruction cycle is four clocks
`default_nettype none
module pps_core (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic [pps_pkg::INSN_W-1:0] fetch_word,
  input wire logic [2:0] insn_class,
  input wire logic [pps_pkg::PC_W-1:0] insn_target,
  input wire logic skip_taken,
  input wire logic irq_pending,
  input wire logic [pps_pkg::PC_W-1:0] irq_vector,
  output logic [pps_pkg::PC_W-1:0] fetch_addr,
  output logic fetch_strobe,
  output logic [1:0] instruction_phases,
  output logic phase_one,
  output logic irq_ack,
  output logic [pps_pkg::INSN_W-1:0] exec_word,
  output logic exec_valid
);
  logic [1:0] phase_reg;
  logic [pps_pkg::PC_W-1:0] pc_reg;
  logic [pps_pkg::PC_W-1:0] pc_next;
  logic [pps_pkg::INSN_W-1:0] ir_reg;
  logic ir_valid_reg;
  logic [1:0] stall_reg;
  logic [1:0] stall_next;
  logic dummy_reg;
  logic ack_reg;
  logic wr_pend_reg;
  logic [pps_pkg::PCL_W-1:0] wr_byte_reg;
  logic [31:0] rdata_reg;
  logic [2:0] last_class_reg;
  logic cycle_end;
  logic exec_now;
  logic take_irq;
  logic do_push;
  logic do_pop;
  logic flush;
  logic [pps_pkg::PC_W-1:0] stack_top;
  logic [pps_pkg::SP_W-1:0] stack_depth;
  logic stack_full;
  logic stack_ovf;
  logic [pps_pkg::PC_W-1:0] push_pc;
  logic apb_setup;
  logic apb_write;
  logic [31:0] rdata_next;
  pps_pkg::pps_op_t op;

  function automatic logic is_branch(input pps_pkg::pps_op_t o);
    return o == pps_pkg::PPS_OP_JUMP || o == pps_pkg::PPS_OP_CALL ||
           o == pps_pkg::PPS_OP_RET;
  endfunction

  function automatic logic addr_hit(input logic [11:0] a,
                                    input logic [11:0] off);
    return a == off;
  endfunction

  assign op = pps_pkg::pps_op_t'(insn_class);

  // four-phase generator
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      phase_reg <= pps_pkg::PHASE_ONE;
    else
      phase_reg <= phase_reg + 2'h1;
  end

  assign cycle_end = (phase_reg == pps_pkg::PHASE_LAST);
  assign instruction_phases = phase_reg;
  assign phase_one = (phase_reg == pps_pkg::PHASE_ONE);
  assign fetch_addr = pc_reg;
  assign fetch_strobe = phase_one;
  // a pending page write or an accepted interrupt displaces the word
  assign exec_now = cycle_end && ir_valid_reg && stall_reg == 2'h0 &&
                    !wr_pend_reg && !take_irq;
  // a full stack holds off the acknowledge; the request stays pending outside
  assign take_irq = cycle_end && stall_reg == 2'h0 && irq_pending &&
                    !stack_full && !wr_pend_reg;
  assign do_push = take_irq ||
                   (exec_now && !take_irq &&
                    op == pps_pkg::PPS_OP_CALL);
  assign do_pop = exec_now && !take_irq &&
                  op == pps_pkg::PPS_OP_RET;
  // a call saves the word after itself; an interrupt saves the word it
  // displaced, which has not run yet
  assign push_pc = take_irq ? pc_reg : pc_reg + 12'h001;
  assign flush = take_irq || wr_pend_reg ||
                 (exec_now && (is_branch(op) ||
                  (op == pps_pkg::PPS_OP_SKIP && skip_taken)));

  // next pc at the end of each instruction cycle
  always_comb
  begin
    pc_next = pc_reg + 12'h001;
    stall_next = (stall_reg != 2'h0) ? stall_reg - 2'h1 : 2'h0;
    if (cycle_end)
    begin
      if (stall_reg != 2'h0)
        pc_next = pc_reg;
      else if (wr_pend_reg)
      begin
        pc_next = {pc_reg[pps_pkg::PC_W-1:pps_pkg::PCL_W],
                   wr_byte_reg};
        stall_next = 2'h1;
      end
      else if (take_irq)
      begin
        pc_next = irq_vector;
        stall_next = 2'h1;
      end
      else if (exec_now)
      begin
        case (op)
          pps_pkg::PPS_OP_JUMP, pps_pkg::PPS_OP_CALL:
          begin
            pc_next = insn_target;
            stall_next = 2'h1;
          end
          pps_pkg::PPS_OP_RET:
          begin
            pc_next = stack_top;
            stall_next = 2'h1;
          end
          pps_pkg::PPS_OP_EXT:
          begin
            pc_next = pc_reg + 12'h001;
            stall_next = 2'h1;
          end
          pps_pkg::PPS_OP_SKIP:
          begin
            pc_next = pc_reg + 12'h001;
            // the word after the skip is dropped, so step over it
            if (skip_taken)
            begin
              pc_next = pc_reg + 12'h002;
              stall_next = 2'h1;
            end
          end
          default: pc_next = pc_reg + 12'h001;
        endcase
      end
    end
    else
    begin
      pc_next = pc_reg;
      stall_next = stall_reg;
    end
  end

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      pc_reg <= pps_pkg::RESET_VECTOR;
    else
      pc_reg <= pc_next;
  end

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      stall_reg <= 2'h0;
    else
      stall_reg <= stall_next;
  end

  // prefetch register: word fetched in phase one executes at the end of the same cycle
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      ir_reg <= '0;
      ir_valid_reg <= 1'b0;
    end
    else if (cycle_end && flush)
      ir_valid_reg <= 1'b0;
    else if (phase_one)
    begin
      ir_reg <= fetch_word;
      ir_valid_reg <= 1'b1;
    end
  end

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      dummy_reg <= 1'b0;
    else if (cycle_end)
      dummy_reg <= (stall_next != 2'h0);
  end

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      ack_reg <= 1'b0;
    else
      ack_reg <= take_irq;
  end

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      last_class_reg <= 3'h0;
    else if (exec_now)
      last_class_reg <= insn_class;
  end

  assign irq_ack = ack_reg;
  assign exec_word = ir_reg;
  assign exec_valid = exec_now;

  // apb slave: zero wait states, so every access completes in two clocks
  assign pready = 1'b1;
  assign pslverr = 1'b0;
  assign prdata = rdata_reg;
  assign apb_setup = psel && !penable;
  assign apb_write = psel && penable && pwrite;

  // a write is held until the cycle boundary, then acts as a page jump
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      wr_pend_reg <= 1'b0;
      wr_byte_reg <= '0;
    end
    else if (apb_write && addr_hit(paddr, pps_pkg::PCL_OFFSET))
    begin
      wr_pend_reg <= 1'b1;
      wr_byte_reg <= pwdata[pps_pkg::PCL_W-1:0];
    end
    else if (cycle_end && stall_reg == 2'h0)
      wr_pend_reg <= 1'b0;
  end

  // status shows flags and the last executed class; the pointer itself stays hidden
  function automatic logic [31:0] status_word(input logic full_f,
                                              input logic ovf_f,
                                              input logic dummy_f,
                                              input logic [2:0] cls);
    logic [31:0] w;
    w = '0;
    w[pps_pkg::ST_FULL_BIT] = full_f;
    w[pps_pkg::ST_OVF_BIT] = ovf_f;
    w[pps_pkg::ST_DUMMY_BIT] = dummy_f;
    w[pps_pkg::ST_PCH_LSB +: 3] = cls;
    return w;
  endfunction

  // read data is taken in the setup cycle so it stands through the access
  always_comb
  begin
    rdata_next = rdata_reg;
    if (apb_setup && !pwrite)
    begin
      if (addr_hit(paddr, pps_pkg::PCL_OFFSET))
        rdata_next = {24'h000000, pc_reg[pps_pkg::PCL_W-1:0]};
      else if (addr_hit(paddr, pps_pkg::STATUS_OFFSET))
        rdata_next = status_word(stack_full, stack_ovf, dummy_reg,
                                 last_class_reg);
      else if (addr_hit(paddr, pps_pkg::INSN_OFFSET))
        rdata_next = {16'h0000, ir_reg};
      else
        rdata_next = 32'h00000000;
    end
  end

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      rdata_reg <= '0;
    else
      rdata_reg <= rdata_next;
  end

  pps_stack u_stack (
    .pclk(pclk),
    .presetn(presetn),
    .push(do_push),
    .pop(do_pop),
    .push_data(push_pc),
    .top_data(stack_top),
    .depth(stack_depth),
    .full(stack_full),
    .overflow(stack_ovf)
  );

  logic unused_ok;
  assign unused_ok = ^stack_depth;
endmodule
`default_nettype wire

//--- pps_pkg.sv
// Purpose: shared constants for the program sequencing core
// Assumes: 32-bit apb register access, two clocks
// Notes: opcode classes are presented decoded on the instruction port
`default_nettype none
package pps_pkg;
  localparam int PC_W = 12;
  localparam int PCL_W = 8;
  localparam int PCH_W = 4;
  localparam int STACK_DEPTH = 6;
  localparam int SP_W = 3;
  localparam int INSN_W = 16;
  localparam logic [PC_W-1:0] RESET_VECTOR = 12'h000;
  localparam logic [1:0] PHASE_ONE = 2'h0;
  localparam logic [1:0] PHASE_LAST = 2'h3;
  // register byte offsets
  localparam logic [11:0] PCL_OFFSET = 12'h000;
  localparam logic [11:0] STATUS_OFFSET = 12'h004;
  localparam logic [11:0] INSN_OFFSET = 12'h008;
  // status field positions
  localparam int ST_SP_LSB = 0;
  localparam int ST_FULL_BIT = 4;
  localparam int ST_OVF_BIT = 5;
  localparam int ST_DUMMY_BIT = 6;
  localparam int ST_PCH_LSB = 8;
  // decoded instruction class fed by the decoder
  typedef enum logic [2:0] {
    PPS_OP_SEQ, PPS_OP_EXT, PPS_OP_JUMP, PPS_OP_CALL,
    PPS_OP_RET, PPS_OP_SKIP
  } pps_op_t;
endpackage
`default_nettype wire

//--- pps_stack.sv
// Purpose: six-level return stack holding program counter values
// Assumes: push and pop never both asserted
// Notes: only the full and overflow flags are visible to software; overflow drops the oldest entry
`default_nettype none
module pps_stack (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic push,
  input wire logic pop,
  input wire logic [pps_pkg::PC_W-1:0] push_data,
  output logic [pps_pkg::PC_W-1:0] top_data,
  output logic [pps_pkg::SP_W-1:0] depth,
  output logic full,
  output logic overflow
);
  logic [pps_pkg::PC_W-1:0] entry_reg [pps_pkg::STACK_DEPTH];
  logic [pps_pkg::SP_W-1:0] sp_reg;
  logic ovf_reg;
  logic [pps_pkg::PC_W-1:0] shift_in [pps_pkg::STACK_DEPTH];

  assign full = (sp_reg == pps_pkg::SP_W'(pps_pkg::STACK_DEPTH));
  assign depth = sp_reg;
  assign overflow = ovf_reg;
  assign top_data = (sp_reg == '0) ? pps_pkg::RESET_VECTOR
                                   : entry_reg[sp_reg - 3'h1];

  // reset leaves the pointer at zero, stack empty
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      sp_reg <= '0;
    else if (push && !full)
      sp_reg <= sp_reg + 3'h1;
    else if (pop && sp_reg != '0)
      sp_reg <= sp_reg - 3'h1;
  end

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      ovf_reg <= 1'b0;
    else if (push && full)
      ovf_reg <= 1'b1;
  end

  // full push shifts every entry down so the first saved value falls off
  for (genvar i = 0; i < pps_pkg::STACK_DEPTH; i++)
  begin : g_ent
    // the top slot takes the new value, every other slot its upper neighbour
    if (i == pps_pkg::STACK_DEPTH - 1)
    begin : g_top
      assign shift_in[i] = push_data;
    end
    else
    begin : g_mid
      assign shift_in[i] = entry_reg[i+1];
    end
    always_ff @(posedge pclk or negedge presetn)
    begin
      if (!presetn)
        entry_reg[i] <= '0;
      else if (push && full)
        entry_reg[i] <= shift_in[i];
      else if (push && sp_reg == pps_pkg::SP_W'(i))
        entry_reg[i] <= push_data;
    end
  end
endmodule
`default_nettype wire

//--- pps_core_assertions.sv
// Purpose: port checks on the sequencing core
// Assumes: bound to every pps_core
// Notes: pc step check holds off on a bus write or interrupt; jump check on interrupt only, skip check never
`default_nettype none
module pps_core_checker (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic pwrite,
  input wire logic [2:0] insn_class,
  input wire logic [11:0] insn_target,
  input wire logic skip_taken,
  input wire logic irq_pending,
  input wire logic [11:0] fetch_addr,
  input wire logic fetch_strobe,
  input wire logic [1:0] instruction_phases,
  input wire logic phase_one,
  input wire logic irq_ack,
  input wire logic exec_valid
);
  timeunit 1ns;
  timeprecision 1ps;
  logic quiet;
  logic redir;
  default clocking cb @(posedge pclk);
  endclocking
  default disable iff (!presetn);
  assign quiet = !irq_pending && !(psel && pwrite);
  assign redir = (insn_class inside {3'h1, 3'h2, 3'h3, 3'h4}) ||
    (insn_class == 3'h5 && skip_taken);
  a_phase_wrap: assert property (
    instruction_phases == 2'h3 |=> instruction_phases == 2'h0)
    else $error("phase did not wrap");
  a_phase_step: assert property (
    instruction_phases != 2'h3 |=>
    instruction_phases == $past(instruction_phases) + 2'h1)
    else $error("phase skipped");
  a_fetch_phase: assert property (
    fetch_strobe == phase_one && phase_one == (instruction_phases == 2'h0))
    else $error("fetch outside phase one");
  a_branch_dummy: assert property (
    exec_valid && redir |-> ##4 !exec_valid)
    else $error("no dummy cycle");
  a_seq_overlap: assert property (
    quiet [*5] ##0 (exec_valid && !redir) ##1 quiet [*3] |=> exec_valid)
    else $error("sequential stall");
  a_pc_step: assert property (
    quiet [*5] ##0 (exec_valid && !redir) |=>
    fetch_addr == $past(fetch_addr) + 12'h1)
    else $error("pc not incremented");
  a_skip_step: assert property (
    exec_valid && insn_class == 3'h5 && skip_taken |=>
    fetch_addr == $past(fetch_addr) + 12'h2)
    else $error("skip did not pass one word");
  a_jump_load: assert property (
    exec_valid && insn_class inside {3'h2, 3'h3} && !irq_pending |=>
    fetch_addr == $past(insn_target))
    else $error("target not loaded");
  a_ack_pulse: assert property (
    irq_ack |-> $past(irq_pending) ##1 !irq_ack)
    else $error("bad acknowledge pulse");
endmodule
bind pps_core pps_core_checker u_pps_core_checker (
  .pclk(pclk), .presetn(presetn), .psel(psel), .pwrite(pwrite),
  .insn_class(insn_class), .insn_target(insn_target),
  .skip_taken(skip_taken), .irq_pending(irq_pending),
  .fetch_addr(fetch_addr), .fetch_strobe(fetch_strobe),
  .instruction_phases(instruction_phases), .phase_one(phase_one),
  .irq_ack(irq_ack), .exec_valid(exec_valid)
);
`default_nettype wire

//--- pps_prog_mem.sv
// Purpose: program memory model feeding fetched words
// Assumes: word content is a pattern of its address
// Notes: the bus toggles outside phase one, so the fetched word shows again one and three clocks later
`default_nettype none
module pps_prog_mem (
  input wire logic pclk,
  input wire logic [11:0] fetch_addr,
  input wire logic fetch_strobe,
  output logic [15:0] fetch_word
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [15:0] last_reg = 16'h0000;
  always_ff @(posedge pclk)
  begin
    last_reg <= fetch_strobe ? {4'hA, fetch_addr} : ~last_reg;
  end
  assign fetch_word = fetch_strobe ? {4'hA, fetch_addr} : last_reg;
endmodule
`default_nettype wire

//--- tb_pps_core.sv
// Purpose: self-checking bench for the sequencing core
// Assumes: the bench stands in for the decoder
// Notes: the pc pushed by an interrupt is consumed, not compared
`default_nettype none
module tb_pps_core;
  timeunit 1ns;
  timeprecision 1ps;
  logic pclk = 0, presetn = 0, psel = 0, penable = 0, pwrite = 0;
  logic [11:0] paddr = 0, insn_target = 0, irq_vector = 12'h0F0;
  logic [31:0] pwdata = 0, prdata, rd;
  logic [2:0] insn_class = 0;
  logic skip_taken = 0, irq_pending = 0;
  logic pready, pslverr, fetch_strobe, phase_one, irq_ack, exec_valid;
  logic [15:0] fetch_word, exec_word;
  logic [11:0] fetch_addr, ra;
  logic [1:0] instruction_phases;
  logic [11:0] stk[$];
  int err_count = 0, checked = 0, cycles = 0;
  pps_core u_pps_core (.pclk(pclk), .presetn(presetn), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
    .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .fetch_word(fetch_word), .insn_class(insn_class),
    .insn_target(insn_target), .skip_taken(skip_taken),
    .irq_pending(irq_pending), .irq_vector(irq_vector),
    .fetch_addr(fetch_addr), .fetch_strobe(fetch_strobe),
    .instruction_phases(instruction_phases), .phase_one(phase_one),
    .irq_ack(irq_ack), .exec_word(exec_word), .exec_valid(exec_valid));
  pps_prog_mem u_pps_prog_mem (.pclk(pclk), .fetch_addr(fetch_addr),
    .fetch_strobe(fetch_strobe), .fetch_word(fetch_word));
  always #2 pclk = ~pclk;
  always @(posedge pclk)
  begin
    cycles++;
    if (cycles == 20000)
    begin
      err_count++;
      finish_test();
    end
  end
  task automatic finish_test();
    if (err_count == 0 && checked > 0)
      $display("Result: passed");
    else
      $display("Result: failed");
    $finish;
  endtask
  task automatic chk(string s, logic [31:0] e, logic [31:0] g);
    checked++;
    if (g !== e)
    begin
      $display("unexpected %s expected %h seen %h", s, e, g);
      err_count++;
    end
  endtask
  function automatic logic [11:0] next_pc(logic [2:0] c, logic [11:0] a,
    logic [11:0] t, logic s);
    if (c == 3'h2 || c == 3'h3)
      return t;
    return (c == 3'h5 && s) ? a + 12'h002 : a + 12'h001;
  endfunction
  task automatic apb(logic w, logic [11:0] a, logic [31:0] d);
    @(posedge pclk);
    psel <= 1'h1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'h1;
    @(posedge pclk);
    while (pready !== 1'h1)
      @(posedge pclk);
    rd = prdata;
    chk("pslverr", 0, pslverr);
    psel <= 1'h0;
    penable <= 1'h0;
  endtask
  // returns the pc seen while the instruction executes
  task automatic issue(logic [2:0] c, logic [11:0] t, logic sk);
    int n;
    @(posedge pclk);
    insn_class <= c;
    insn_target <= t;
    skip_taken <= sk;
    n = 0;
    do
    begin
      @(negedge pclk);
      n++;
    end
    while (exec_valid !== 1'h1 && n < 40);
    chk("exec", 1, exec_valid);
    chk("word", {4'hA, fetch_addr}, exec_word);
    ra = fetch_addr;
    @(posedge pclk);
    insn_class <= 3'h0;
  endtask
  initial
  begin
    logic [2:0] c;
    logic [3:0] hi;
    logic [7:0] v;
    int n;
    void'($urandom(81));
    repeat (16) @(posedge pclk);
    presetn <= 1'h1;
    @(negedge pclk);
    chk("reset pc", 0, fetch_addr);
    repeat (40)
    begin
      c = 3'($urandom_range(0, 3));
      c = (c == 3'h3) ? 3'h5 : c;
      issue(c, 12'($urandom), 1'($urandom));
      @(negedge pclk);
      chk("pc", next_pc(c, ra, insn_target, skip_taken),
        fetch_addr);
    end
    for (int i = 0; i < 7; i++)
    begin
      issue(3'h3, 12'(i * 256 + 64), 1'h0);
      stk.push_back(ra + 12'h001);
      if (stk.size() > 6)
        stk.delete(0);
      @(negedge pclk);
      chk("call", i * 256 + 64, fetch_addr);
    end
    apb(1'h0, pps_pkg::STATUS_OFFSET, 0);
    chk("full", 3'h3, rd[5:4]);
    irq_pending <= 1'h1;
    repeat (12)
    begin
      @(negedge pclk);
      chk("ack held", 0, irq_ack);
    end
    issue(3'h4, 0, 1'h0);
    @(negedge pclk);
    chk("return", stk.pop_back(), fetch_addr);
    n = 0;
    while (irq_ack !== 1'h1 && n < 20)
    begin
      @(negedge pclk);
      n++;
    end
    chk("ack", 1, irq_ack);
    chk("vector", irq_vector, fetch_addr);
    @(posedge pclk);
    irq_pending <= 1'h0;
    issue(3'h4, 0, 1'h0);
    repeat (5)
    begin
      issue(3'h4, 0, 1'h0);
      @(negedge pclk);
      chk("return", stk.pop_back(), fetch_addr);
    end
    hi = fetch_addr[11:8];
    v = fetch_addr[7:0] + 8'h10 + 8'($urandom_range(0, 192));
    apb(1'h1, pps_pkg::PCL_OFFSET, {24'h0, v});
    n = 0;
    while (fetch_addr[7:0] !== v && n < 12)
    begin
      @(negedge pclk);
      n++;
    end
    chk("pc write", {hi, v}, fetch_addr);
    apb(1'h0, pps_pkg::PCL_OFFSET, 0);
    chk("pc read", {24'h0, v}, rd);
    apb(1'h0, pps_pkg::INSN_OFFSET, 0);
    chk("insn read", 20'h0000A, rd[31:12]);
    apb(1'h0, 12'h00C, 0);
    chk("unmapped", 0, rd);
    issue(3'h3, 12'h300, 1'h0);
    presetn <= 1'h0;
    repeat (2) @(posedge pclk);
    presetn <= 1'h1;
    apb(1'h0, pps_pkg::STATUS_OFFSET, 0);
    chk("stack empty", 0, rd[5:0]);
    repeat (5) issue(3'h3, 12'h300, 1'h0);
    apb(1'h0, pps_pkg::STATUS_OFFSET, 0);
    chk("five deep", 0, rd[4]);
    issue(3'h3, 12'h300, 1'h0);
    apb(1'h0, pps_pkg::STATUS_OFFSET, 0);
    chk("six deep", 1, rd[4]);
    finish_test();
  end
endmodule
`default_nettype wire
